// [dwp_pkg.sv]
// Constants and types for the deinterlace/denoise writeback packer
`default_nettype none

package dwp_pkg;

  // ************************************************************
  // Register map of the AXI4-Lite slave
  // ************************************************************
  localparam logic [7:0]  DWP_CTRL_OFS    = 8'h00;
  localparam logic [7:0]  DWP_STATUS_OFS  = 8'h04;
  localparam logic [31:0] DWP_CTRL_RST    = 32'h0000_0010;
  localparam logic [1:0]  DWP_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  DWP_RESP_DECERR = 2'h3;

  // Control field positions
  localparam int DWP_GEN_LSB    = 0;
  localparam int DWP_DI_BIT     = 2;
  localparam int DWP_DN_BIT     = 3;
  localparam int DWP_F422_BIT   = 4;
  localparam int DWP_THRESH_LSB = 8;

  // Status field positions
  localparam int DWP_BUSY_BIT   = 0;
  localparam int DWP_LEN_LSB    = 4;
  localparam int DWP_JOBS_LSB   = 16;

  // ************************************************************
  // Generations, message layout and states
  // ************************************************************
  typedef enum logic [1:0] {
    DWP_GEN_PRE6 = 2'h0,
    DWP_GEN_6    = 2'h1,
    DWP_GEN_7UP  = 2'h2
  } dwp_gen_t;

  localparam int         DWP_NLOG     = 12;  // Logical registers, DI on
  localparam int         DWP_NSLOT    = 10;  // Pixel registers captured
  localparam logic [3:0] DWP_DI_MM    = 4'h8;
  localparam logic [3:0] DWP_DI_NB    = 4'h9;
  localparam logic [3:0] DWP_DI_DNL   = 4'ha;
  localparam logic [3:0] DWP_DI_DNC   = 4'hb;
  localparam logic [3:0] DWP_NODI_NB  = 4'h4;
  localparam logic [3:0] DWP_NODI_CH0 = 4'h5;
  localparam logic [3:0] DWP_NODI_LST = 4'h8;

  typedef enum logic [2:0] {
    DWP_S_IDLE = 3'b001,
    DWP_S_LOAD = 3'b010,
    DWP_S_SEND = 3'b100
  } dwp_state_t;

endpackage

`default_nettype wire

// [dwp_packer.sv]
// Deinterlace/denoise writeback message packer with AXI4-Lite control
//
// How it works
// - Motion block: eight dwords, rows 0-3, even positions, highest first
// - Before gen 6: noise byte in dword1 low, history dword0, rest zero
// - Gen 6 noise block dword7 holds vertical then horizontal location
// - Gen 6 DI on: byte sums in dwords 6-4, zero when denoise off
// - Gen 6 DI on: five field differences fill dwords 3, 2, 1 high
// - Gen 6 DI on: moving-pixel count bits 15:8, noise estimate bits 7:0
// - Gen 6 DI off: 4x8 byte sums, noise in dword2, two history dwords
// - Gen 7 DI on: three 16-bit sums then five field differences
// - Gen 7 DI on: dword2 reserved, dword1 tearing/fitting/moving counts, noise
// - Tearing when top-bottom delta exceeds top-top plus bottom-bottom
// - Gen 7 DI off: top then bottom 16-bit sums in dwords 6-4
// - Gen 7 DI off: noise in dword2 low, history dwords 1 and 0
// - Message length depends on generation, denoise and packed 4:2:2
// - DI on: registers 0-7 carry previous and current deinterlaced pixels
// - Register 8 motion block; register 9 noise block when present
// - Registers 10 and 11 carry denoised second field, denoise only; from gen 7, register 11 only for 4:2:2
// - First field rows 0 and 2 denoised, rows 1 and 3 deinterlaced
// - DI off: 16x8 area, nine registers for 4:2:2, else five
// - DI off: luma 0-3, noise block 4, chroma 5-8 for 4:2:2
`default_nettype none

module dwp_packer
  import dwp_pkg::*;
#(
  parameter int NPIX = 64
) (
  // Clock and reset
  input  wire logic               aclk,
  input  wire logic               aresetn,
  // AXI4-Lite write address and data
  input  wire logic [7:0]         s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]         s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  // Job request from the sampler pipeline
  input  wire logic               job_valid,
  output logic                    job_ready,
  input  wire logic [2559:0]      job_pixel_regs,
  input  wire logic [255:0]       motion_measure_block,
  input  wire logic [7:0]         noise_estimate,
  input  wire logic [63:0]        history_bytes,
  input  wire logic [15:0]        loc_x,
  input  wire logic [15:0]        loc_y,
  // Byte sums for gen 6, sum 0 in bits 31:24
  input  wire logic [31:0]        temporal_abs_diff_sum,
  input  wire logic [31:0]        horizontal_abs_diff_sum,
  input  wire logic [31:0]        vertical_abs_diff_sum,
  // Word sums for gen 7 onward, top and bottom areas
  input  wire logic [15:0]        tad_top,
  input  wire logic [15:0]        hcm_top,
  input  wire logic [15:0]        vcm_top,
  input  wire logic [15:0]        tad_bot,
  input  wire logic [15:0]        hcm_bot,
  input  wire logic [15:0]        vcm_bot,
  // Field differences
  input  wire logic [15:0]        cur_top_prev_top_delta,
  input  wire logic [15:0]        cur_bot_prev_bot_delta,
  input  wire logic [15:0]        cur_top_cur_bot_delta,
  input  wire logic [15:0]        cur_top_prev_bot_delta,
  input  wire logic [15:0]        cur_bot_prev_top_delta,
  // Per-pixel deltas for the pixel counts
  input  wire logic [NPIX*8-1:0]  pix_tt_delta,
  input  wire logic [NPIX*8-1:0]  pix_bb_delta,
  input  wire logic [NPIX*8-1:0]  pix_tb_delta,
  // Writeback stream towards the thread
  output logic                    wb_valid,
  input  wire logic               wb_ready,
  output logic [255:0]            wb_data,
  output logic [3:0]              wb_index,
  output logic                    wb_last
);

  // ************************************************************
  // Control and status registers
  // ************************************************************
  logic [31:0]     ctrl_r;
  logic [3:0]      len_r;
  logic [15:0]     jobs_r;
  logic            awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic [1:0]      bresp_r, rresp_r;
  logic [31:0]     rdata_r;
  logic [7:0]      awaddr_q;
  logic [31:0]     wdata_q;
  logic [3:0]      wstrb_q;
  dwp_state_t      state_r;

  // Address decode
  wire             do_write   = !awready_r && !wready_r && !bvalid_r;
  wire             wr_ctrl    = awaddr_q == DWP_CTRL_OFS;
  wire             wr_known   = wr_ctrl || awaddr_q == DWP_STATUS_OFS;
  wire             rd_ctrl    = s_axi_araddr == DWP_CTRL_OFS;
  wire             rd_stat    = s_axi_araddr == DWP_STATUS_OFS;
  wire logic [31:0] status_w  = {jobs_r, 8'h00, len_r, 3'h0,
                                 state_r != DWP_S_IDLE};
  wire logic [31:0] ctrl_nxt;

  genvar gb;
  generate
    for (gb = 0; gb < 4; gb++) begin : g_strb
      assign ctrl_nxt[gb*8 +: 8] = wstrb_q[gb] ? wdata_q[gb*8 +: 8]
                                               : ctrl_r[gb*8 +: 8];
    end
  endgenerate

  // Write channels taken in either order, answered once both are in
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      bvalid_r  <= 1'b0;
      bresp_r   <= DWP_RESP_OKAY;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
      ctrl_r    <= DWP_CTRL_RST;
    end else begin
      if (s_axi_awvalid && awready_r) begin
        awaddr_q  <= s_axi_awaddr;
        awready_r <= 1'b0;
      end
      if (s_axi_wvalid && wready_r) begin
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
        wready_r <= 1'b0;
      end
      if (do_write) begin
        bvalid_r <= 1'b1;
        bresp_r  <= wr_known ? DWP_RESP_OKAY : DWP_RESP_DECERR;
        if (wr_ctrl) ctrl_r <= ctrl_nxt;
      end
      if (bvalid_r && s_axi_bready) begin
        bvalid_r  <= 1'b0;
        awready_r <= 1'b1;
        wready_r  <= 1'b1;
      end
    end
  end

  // Read channel, one answer per address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0000_0000;
      rresp_r   <= DWP_RESP_OKAY;
    end else if (s_axi_arvalid && arready_r) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b1;
      rdata_r   <= rd_ctrl ? ctrl_r : rd_stat ? status_w : 32'h0000_0000;
      rresp_r   <= (rd_ctrl || rd_stat) ? DWP_RESP_OKAY : DWP_RESP_DECERR;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r  <= 1'b0;
      arready_r <= 1'b1;
    end
  end

  // ************************************************************
  // Per-pixel classification
  // ************************************************************
  logic [NPIX-1:0] tear_flag, move_flag;
  logic [7:0]      tear_cnt, move_cnt;
  wire logic [7:0] thresh = ctrl_r[DWP_THRESH_LSB +: 8];

  genvar gp;
  generate
    for (gp = 0; gp < NPIX; gp++) begin : g_pix
      wire logic [8:0] tt_bb = {1'b0, pix_tt_delta[gp*8 +: 8]}
                             + {1'b0, pix_bb_delta[gp*8 +: 8]};
      assign tear_flag[gp] = {1'b0, pix_tb_delta[gp*8 +: 8]} > tt_bb;
      assign move_flag[gp] = pix_tt_delta[gp*8 +: 8] > thresh;
    end
  endgenerate

  // Population counts of the flags
  always_comb begin
    tear_cnt = 8'h00;
    move_cnt = 8'h00;
    for (int i = 0; i < NPIX; i++) begin
      tear_cnt = tear_cnt + {7'h00, tear_flag[i]};
      move_cnt = move_cnt + {7'h00, move_flag[i]};
    end
  end

  // ************************************************************
  // Job capture
  // ************************************************************
  logic [255:0] pix_r [DWP_NSLOT];
  logic [255:0] mm_r;
  logic [7:0]   ne_r, tear_r, move_r;
  logic [63:0]  hist_r;
  logic [31:0]  loc_r, tadb_r, hcmb_r, vcmb_r;
  logic [95:0]  sum16_r;
  logic [79:0]  fd_r;
  dwp_gen_t     gen_r;
  logic         di_r, dn_r, f422_r;

  wire job_take = job_valid && state_r == DWP_S_IDLE;

  always_ff @(posedge aclk) begin
    if (job_take) begin
      for (int i = 0; i < DWP_NSLOT; i++) pix_r[i] <= job_pixel_regs[i*256 +: 256];
      mm_r    <= motion_measure_block;
      ne_r    <= noise_estimate;
      hist_r  <= history_bytes;
      loc_r   <= {loc_y, loc_x};
      tadb_r  <= temporal_abs_diff_sum;
      hcmb_r  <= horizontal_abs_diff_sum;
      vcmb_r  <= vertical_abs_diff_sum;
      sum16_r <= {tad_top, hcm_top, vcm_top, tad_bot, hcm_bot, vcm_bot};
      fd_r    <= {cur_top_prev_top_delta, cur_bot_prev_bot_delta,
                  cur_top_cur_bot_delta, cur_top_prev_bot_delta,
                  cur_bot_prev_top_delta};
      tear_r  <= tear_cnt;
      move_r  <= move_cnt;
    end
  end

  // Mode bits are sampled per job
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gen_r  <= DWP_GEN_PRE6;
      di_r   <= 1'b0;
      dn_r   <= 1'b0;
      f422_r <= 1'b0;
    end else if (job_take) begin
      gen_r  <= dwp_gen_t'(ctrl_r[DWP_GEN_LSB +: 2]);
      di_r   <= ctrl_r[DWP_DI_BIT];
      dn_r   <= ctrl_r[DWP_DN_BIT];
      f422_r <= ctrl_r[DWP_F422_BIT];
    end
  end

  // ************************************************************
  // Noise estimate / denoise history block
  // ************************************************************
  wire logic [7:0]  ne_v  = dn_r ? ne_r : 8'h00;
  wire logic [95:0] sb_v  = dn_r ? {tadb_r, hcmb_r, vcmb_r} : 96'h0;
  wire logic [47:0] s7_v  = dn_r ? sum16_r[95:48] : 48'h0;
  wire logic [7:0]  fit_r = 8'(NPIX) - tear_r;

  wire logic [255:0] nb_pre6 = {192'h0, 24'h0, ne_r, hist_r[31:0]};
  wire logic [255:0] nb_g6di = {loc_r, sb_v, fd_r,
                                move_r, ne_v, hist_r[31:0]};
  wire logic [255:0] nb_g6nd = {loc_r, tadb_r, hcmb_r, vcmb_r, 32'h0,
                                24'h0, ne_r, hist_r};
  wire logic [255:0] nb_g7di = {loc_r, s7_v, fd_r, 32'h0, tear_r,
                                fit_r, move_r, ne_r,
                                hist_r[31:0]};
  wire logic [255:0] nb_g7nd = {loc_r, sum16_r, 32'h0, 24'h0, ne_r,
                                hist_r};

  wire logic [255:0] nb_w = gen_r == DWP_GEN_PRE6 ? nb_pre6
                          : gen_r == DWP_GEN_6    ? (di_r ? nb_g6di : nb_g6nd)
                          : (di_r ? nb_g7di : nb_g7nd);

  // ************************************************************
  // Message composition
  // ************************************************************
  logic [DWP_NLOG-1:0] present;
  logic [3:0]          idx_r, next_idx, msg_len;
  logic                next_ok;

  // Which logical registers the message carries
  always_comb begin
    present = '0;
    if (di_r) begin
      present[8:0] = 9'h1ff;
      present[DWP_DI_NB]  = dn_r || gen_r != DWP_GEN_PRE6;
      present[DWP_DI_DNL] = dn_r;
      present[DWP_DI_DNC] = dn_r && (gen_r != DWP_GEN_7UP || f422_r);
    end else begin
      present[4:0] = 5'h1f;
      present[8:5] = {4{f422_r}};
    end
  end

  // Length and next present register after the current one
  always_comb begin
    msg_len  = 4'h0;
    next_idx = idx_r;
    next_ok  = 1'b0;
    for (int i = 0; i < DWP_NLOG; i++) begin
      msg_len = msg_len + {3'h0, present[i]};
    end
    for (int i = DWP_NLOG - 1; i >= 0; i--) begin
      if (present[i] && (idx_r == 4'hf || 4'(i) > idx_r)) begin
        next_idx = 4'(i);
        next_ok  = 1'b1;
      end
    end
  end

  // Source selection for a logical register
  wire logic [3:0] di_slot = next_idx >= DWP_DI_DNL ? next_idx - 4'h2
                                                    : next_idx;
  wire logic [3:0] nd_slot = next_idx >= DWP_NODI_CH0 ? next_idx - 4'h1
                                                      : next_idx;
  wire logic [3:0] slot    = di_r ? di_slot : nd_slot;
  wire             is_mm   = di_r && next_idx == DWP_DI_MM;
  wire             is_nb   = di_r ? next_idx == DWP_DI_NB
                                  : next_idx == DWP_NODI_NB;
  // First-field rows 0/2 arrive already denoised inside the pixel slots
  wire logic [255:0] src_w = is_mm ? mm_r : is_nb ? nb_w
                                   : pix_r[slot];
  wire logic [3:0] last_idx = di_r ? (present[DWP_DI_DNC] ? DWP_DI_DNC
                                   : present[DWP_DI_DNL] ? DWP_DI_DNL
                                   : present[DWP_DI_NB] ? DWP_DI_NB
                                   : DWP_DI_MM)
                                   : (f422_r ? DWP_NODI_LST : DWP_NODI_NB);

  // ************************************************************
  // Sequencer and writeback stream
  // ************************************************************
  logic         wb_valid_r, wb_last_r, job_ready_r;
  logic [255:0] wb_data_r;
  wire          wb_fire = wb_valid_r && wb_ready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r     <= DWP_S_IDLE;
      job_ready_r <= 1'b1;
      wb_valid_r  <= 1'b0;
      wb_last_r   <= 1'b0;
      wb_data_r   <= '0;
      idx_r       <= 4'hf;
      len_r       <= 4'h0;
      jobs_r      <= 16'h0000;
    end else begin
      unique case (state_r)
        DWP_S_IDLE: begin
          if (job_take) begin
            state_r     <= DWP_S_LOAD;
            job_ready_r <= 1'b0;
          end
        end
        DWP_S_LOAD: begin
          // idx_r holds all-ones, so next_idx is the first present one
          state_r    <= DWP_S_SEND;
          wb_valid_r <= 1'b1;
          wb_data_r  <= src_w;
          idx_r      <= next_idx;
          wb_last_r  <= next_idx == last_idx;
          len_r      <= msg_len;
        end
        DWP_S_SEND: begin
          if (wb_fire && next_ok) begin
            wb_data_r <= src_w;
            idx_r     <= next_idx;
            wb_last_r <= next_idx == last_idx;
          end else if (wb_fire) begin
            state_r     <= DWP_S_IDLE;
            wb_valid_r  <= 1'b0;
            wb_last_r   <= 1'b0;
            idx_r       <= 4'hf;
            job_ready_r <= 1'b1;
            jobs_r      <= jobs_r + 16'h0001;
          end
        end
      endcase
    end
  end

  // Port drives
  assign s_axi_awready = awready_r;
  assign s_axi_wready  = wready_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;
  assign job_ready     = job_ready_r;
  assign wb_valid      = wb_valid_r;
  assign wb_data       = wb_data_r;
  assign wb_index      = idx_r;
  assign wb_last       = wb_last_r;

  // ************************************************************
  // Assertions
  // ************************************************************
  logic [3:0] sent_r;
  always_ff @(posedge aclk) begin
    if (!aresetn || job_take) sent_r <= 4'h0;
    else if (wb_fire) sent_r <= sent_r + 4'h1;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence seq_take;
    job_valid && job_ready_r;
  endsequence
  sequence seq_first;
    ##1 !wb_valid_r ##1 wb_valid_r && idx_r == 4'h0;
  endsequence

  a_first_register: assert property (seq_take |-> seq_first)
    else $error("first writeback register not index 0");
  a_stall_hold: assert property (wb_valid_r && !wb_ready |=>
    wb_valid_r && $stable(wb_data_r) && $stable(idx_r))
    else $error("writeback changed while stalled");
  a_index_rises: assert property (wb_fire && !wb_last_r |=>
    wb_valid_r && idx_r > $past(idx_r))
    else $error("writeback index did not rise");
  a_length_match: assert property (wb_fire && wb_last_r |->
    sent_r + 4'h1 == msg_len)
    else $error("register count differs from length");
  a_motion_slot: assert property (wb_valid_r && di_r && idx_r == DWP_DI_MM
    |-> wb_data_r == mm_r)
    else $error("motion block not in register 8");
  a_pre6_zero: assert property (wb_valid_r && di_r && idx_r == DWP_DI_NB
    && gen_r == DWP_GEN_PRE6 |-> wb_data_r[255:40] == '0)
    else $error("reserved noise dwords not zero");
  a_dn_off_sums: assert property (wb_valid_r && di_r && !dn_r &&
    idx_r == DWP_DI_NB && gen_r == DWP_GEN_6 |-> wb_data_r[223:128] == '0)
    else $error("byte sums not zero with denoise off");
  a_tear_fit: assert property (wb_valid_r && di_r && idx_r == DWP_DI_NB &&
    gen_r == DWP_GEN_7UP |-> wb_data_r[63:56] + wb_data_r[55:48]
    == 8'(NPIX))
    else $error("tearing plus fitting differs from pixels");
  a_nodi_short: assert property (wb_fire && wb_last_r && !di_r && !f422_r
    |-> idx_r == DWP_NODI_NB)
    else $error("short message did not end at noise block");

endmodule

`default_nettype wire

// [dwp_sink.sv]
// Thread-side model that takes the writeback stream
`default_nettype none

module dwp_sink (
  // Clock, reset and bench control
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         stall,
  input  wire logic         clr,
  // Writeback stream
  input  wire logic         wb_valid,
  output logic              wb_ready,
  input  wire logic [255:0] wb_data,
  input  wire logic [3:0]   wb_index,
  input  wire logic         wb_last
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [255:0] dat [12];
  logic [3:0]   idx [12];
  int           n    = 0;
  logic         done = 1'b0;

  initial wb_ready = 1'b0;

  // Ready toggles when stalled; each handshake stores one register
  always @(posedge aclk) begin
    wb_ready <= !aresetn || !stall || !wb_ready;
    if (clr) begin
      n    <= 0;
      done <= 1'b0;
    end else if (wb_valid && wb_ready) begin
      if (n < 12) begin
        dat[n] <= wb_data;
        idx[n] <= wb_index;
      end
      n    <= n + 1;
      done <= wb_last;
    end
  end
endmodule

`default_nettype wire

// [dwp_packer_bench.sv]
// Self-checking bench for the writeback packer
`default_nettype none

module dwp_packer_bench;
  import dwp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0, aresetn = 1'b0, stall = 1'b0, clr = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, job_valid = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf, wb_index;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, job_ready, wb_valid, wb_ready, wb_last;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [2559:0] job_pixel_regs;
  logic [255:0] motion_measure_block, wb_data;
  logic [7:0] noise_estimate = 8'h5a;
  logic [63:0] history_bytes = 64'h8877_6655_4433_2211;
  logic [15:0] loc_x = 16'h1234, loc_y = 16'h5678;
  logic [31:0] temporal_abs_diff_sum = 32'ha1a2_a3a4;
  logic [31:0] horizontal_abs_diff_sum = 32'hb1b2_b3b4;
  logic [31:0] vertical_abs_diff_sum = 32'hc1c2_c3c4;
  logic [15:0] tad_top = 16'h1001, hcm_top = 16'h2002, vcm_top = 16'h3003;
  logic [15:0] tad_bot = 16'h4004, hcm_bot = 16'h5005, vcm_bot = 16'h6006;
  logic [15:0] cur_top_prev_top_delta = 16'h0d01;
  logic [15:0] cur_bot_prev_bot_delta = 16'h0d02;
  logic [15:0] cur_top_cur_bot_delta = 16'h0d03;
  logic [15:0] cur_top_prev_bot_delta = 16'h0d04;
  logic [15:0] cur_bot_prev_top_delta = 16'h0d05;
  // Eight pixels: half tearing, half fitting, half moving
  logic [63:0] pix_tt_delta = {4{16'h0501}};
  logic [63:0] pix_bb_delta = {8{8'h01}}, pix_tb_delta = {8{8'h03}};
  int err_total = 0, checked = 0, cyc = 0, lastn = 0;

  dwp_packer #(.NPIX(8)) dut (.*);
  dwp_sink sink (.*);

  always #2.5 aclk = ~aclk;

  // Run ceiling
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      summarize();
    end
  end

  // ************************************************************
  // Compare, bus and job tasks
  // ************************************************************
  task automatic cmpw(input logic [255:0] g, input logic [255:0] e);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %0t reg %h exp %h", $time, g, e);
    end
  endtask

  task automatic cmpr(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %0t value %h exp %h", $time, g, e);
    end
  endtask

  task automatic summarize;
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // Expected noise and history register per generation and mode
  function automatic logic [255:0] nb(int g, bit di, bit dn);
    logic [7:0] m;
    logic [79:0] fd;
    m = dn ? 8'hff : 8'h00;
    fd = {cur_top_prev_top_delta, cur_bot_prev_bot_delta,
          cur_top_cur_bot_delta, cur_top_prev_bot_delta,
          cur_bot_prev_top_delta};
    if (g == 0) return {216'h0, noise_estimate, history_bytes[31:0]};
    if (g == 1 && di)
      return {loc_y, loc_x, temporal_abs_diff_sum & {4{m}},
              horizontal_abs_diff_sum & {4{m}},
              vertical_abs_diff_sum & {4{m}}, fd, 8'h04,
              noise_estimate & m, history_bytes[31:0]};
    if (g == 1)
      return {loc_y, loc_x, temporal_abs_diff_sum, horizontal_abs_diff_sum,
              vertical_abs_diff_sum, 56'h0, noise_estimate, history_bytes};
    if (di)
      return {loc_y, loc_x, tad_top & {2{m}}, hcm_top & {2{m}},
              vcm_top & {2{m}}, fd, 32'h0, 24'h040404, noise_estimate,
              history_bytes[31:0]};
    return {loc_y, loc_x, tad_top, hcm_top, vcm_top, tad_bot, hcm_bot,
            vcm_bot, 56'h0, noise_estimate, history_bytes};
  endfunction

  task automatic run(int g, bit di, bit dn, bit f);
    logic [1:0] r;
    logic [255:0] e, mk, x;
    int n;
    bit on;
    wr(DWP_CTRL_OFS, {16'h0, 8'h02, 3'h0, f, dn, di, 2'(g)}, r);
    stall <= dn ^ f;
    clr <= 1'b1;
    @(posedge aclk);
    clr <= 1'b0;
    job_valid <= 1'b1;
    do @(posedge aclk); while (job_ready !== 1'b1);
    job_valid <= 1'b0;
    do @(posedge aclk); while (sink.done !== 1'b1 && cyc < 30000);
    repeat (3) @(posedge aclk);
    mk = '1;
    if (g == 1 && di && dn) mk[199:128] = 72'h00_ffff_ff00_ffff_ff00;
    n = 0;
    for (int k = 0; k < 12; k++) begin
      on = di ? (k <= 8 || (k == 9 && (dn || g != 0)) || (k == 10 && dn)
                 || (k == 11 && dn && (g != 2 || f)))
              : (k <= 4 || (k <= 8 && f));
      if (on) begin
        e = (k == (di ? 9 : 4)) ? nb(g, di, dn)
          : (di && k == 8) ? motion_measure_block
          : job_pixel_regs[(k - ((di && k > 8) ? 2 : (!di && k > 4)))*256
                           +: 256];
        x = sink.dat[n] & mk;
        cmpr(32'(sink.idx[n]), k);
        if (k != (di ? 9 : 4)) cmpw(sink.dat[n], e);
        else if (g == 0) cmpw(x, e & mk);
        else if (g == 1) cmpw(x, e & mk);
        else cmpw(x, e);
        n++;
      end
    end
    cmpr(sink.n, n);
    lastn = n;
  endtask

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    for (int i = 0; i < 10; i++)
      job_pixel_regs[i*256 +: 256] = {32{8'(8'h10 + i)}};
    for (int i = 0; i < 8; i++)
      motion_measure_block[i*32 +: 32] = 32'hc0de_0000 + 32'(i);
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rd(DWP_CTRL_OFS, d, r);
    cmpr(d, DWP_CTRL_RST);
    cmpr(32'(r), 32'(DWP_RESP_OKAY));
    rd(8'h08, d, r);
    cmpr(32'(r), 32'(DWP_RESP_DECERR));
    wr(8'h0c, 32'h0000_00ff, r);
    cmpr(32'(r), 32'(DWP_RESP_DECERR));
    wr(DWP_STATUS_OFS, 32'hffff_ffff, r);
    cmpr(32'(r), 32'(DWP_RESP_OKAY));
    for (int g = 0; g < 3; g++)
      for (int m = 0; m < 8; m++)
        run(g, m[2], m[1], m[0]);
    rd(DWP_STATUS_OFS, d, r);
    cmpr(d & 32'hffff_00f1, {16'd24, 8'h0, 4'(lastn), 4'h0});
    summarize();
  end
endmodule

`default_nettype wire
